// [verilog/ssw_link.v]
// Serial SRAM host link front end with pause and dual/quad widths
// Notes on behaviour
// - Sample input line on rising serial clock
// - Change output only after falling serial clock
// - Pause suspends transfer, sequence state kept
// - Pause starting with clock high waits falling edge
// - While paused ignore clock and input
// - Release with clock high resumes at falling edge
// - Output floats on pause fall, drives on rise
// - Quad mode: pause disabled, pin is line 3
// - Dual mode: input/output pins are lines 0/1
// - Dual: two bits per clock, MSB first
// - Quad: one nibble per clock, MSB first
// - Enter-dual command selects dual width
// - Enter-quad command selects quad, drops pause
// - Exit-wide in current width restores single bit
// - Enter-dual code is 0x3b
// - Enter-quad code is 0x38
// - Exit-wide code is 0xff
`include "ssw_map.vh"
`timescale 1ns/100ps
`default_nettype none
module ssw_link (
  input wire i_clk,
  input wire i_rstn,
  input wire i_cs_n,
  input wire i_sck,
  input wire i_line0,
  input wire i_line1,
  input wire i_line2,
  input wire i_line3,
  output reg o_line0,
  output reg o_line0_oe,
  output reg o_line1,
  output reg o_line1_oe,
  output reg o_line2,
  output reg o_line2_oe,
  output reg o_line3,
  output reg o_line3_oe,
  output reg [7:0] o_cmd,
  output reg o_cmd_vld,
  output reg [15:0] o_addr,
  output reg o_addr_vld,
  output reg [7:0] o_wdata,
  output reg o_wdata_vld,
  output reg o_rd_req,
  input wire [7:0] i_rdata,
  input wire i_rd_dir,
  output reg [1:0] o_width,
  output reg o_paused
);
  // ***********************************************
  // Reset release and pin synchronisers
  // ***********************************************
  reg [1:0] rst_sync_q;
  wire rstn;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rstn = rst_sync_q[1];

  reg [6:0] meta_q;
  reg [6:0] sync_q;
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 7'h61;
      sync_q <= 7'h61;
    end else begin
      meta_q <= {i_cs_n, i_line3, i_line2, i_line1, i_line0, i_sck, 1'h1};
      sync_q <= meta_q;
    end
  end
  wire cs_n = sync_q[6];
  wire [3:0] din = sync_q[5:2];
  wire sck = sync_q[1];

  reg sck_q;
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'h0;
    end else begin
      sck_q <= sck;
    end
  end
  wire sck_rise = sck & ~sck_q;
  wire sck_fall = ~sck & sck_q;

  // ***********************************************
  // Sequence progress for the pause gate
  // ***********************************************
  reg busy_q;
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'h0;
    end else begin
      if (cs_n) begin
        busy_q <= 1'h0;
      end else if (sck_rise) begin
        busy_q <= 1'h1;
      end
    end
  end

  // ***********************************************
  // Width and pause control
  // ***********************************************
  reg [1:0] width_q;
  reg pause_q;
  wire quad = (width_q == `SSW_WIDTH_QUAD);
  wire dual = (width_q == `SSW_WIDTH_DUAL);
  wire hold_n = din[3];
  // Pause only in single or dual width, selected and mid-sequence
  wire pause_ok = ~quad & ~cs_n & busy_q;
  reg pause_d;
  always @* begin
    pause_d = 1'h0;
    if (pause_ok) begin
      case (pause_q)
        1'h0: pause_d = ~hold_n & ~sck;
        1'h1: pause_d = ~hold_n | sck;
        default: pause_d = 1'h0;
      endcase
    end
  end
  wire pause_now = pause_ok & ~hold_n;
  wire active = ~cs_n & ~pause_q & ~pause_d;

  // Bits per clock for the current width
  function [2:0] step_bits;
    input [1:0] w;
    begin
      case (w)
        `SSW_WIDTH_DUAL: step_bits = 3'h2;
        `SSW_WIDTH_QUAD: step_bits = 3'h4;
        default: step_bits = 3'h1;
      endcase
    end
  endfunction
  wire [2:0] step = step_bits(width_q);

  // Width selected by a completed command byte
  function [1:0] cmd_width;
    input [7:0] c;
    input [1:0] w;
    begin
      case (c)
        `SSW_CMD_ENTER_DUAL: cmd_width = `SSW_WIDTH_DUAL;
        `SSW_CMD_ENTER_QUAD: cmd_width = `SSW_WIDTH_QUAD;
        `SSW_CMD_EXIT_WIDE: cmd_width = `SSW_WIDTH_SINGLE;
        default: cmd_width = w;
      endcase
    end
  endfunction

  // ***********************************************
  // Input shifter and sequence tracking
  // ***********************************************
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg [1:0] phase_q;
  reg [1:0] abytes_q;
  reg [7:0] tx_q;
  reg tx_en_q;
  reg [7:0] sh_d;
  always @* begin
    case (width_q)
      `SSW_WIDTH_DUAL: sh_d = {sh_q[5:0], din[1:0]};
      `SSW_WIDTH_QUAD: sh_d = {sh_q[3:0], din[3:0]};
      default: sh_d = {sh_q[6:0], din[0]};
    endcase
  end
  wire [3:0] cnt_d = cnt_q + {1'h0, step};
  wire byte_done = active & sck_rise & (cnt_d == 4'h8);

  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      width_q <= `SSW_WIDTH_SINGLE;
      pause_q <= 1'h0;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      phase_q <= `SSW_PH_CMD;
      abytes_q <= 2'h0;
      o_cmd <= 8'h00;
      o_cmd_vld <= 1'h0;
      o_addr <= 16'h0000;
      o_addr_vld <= 1'h0;
      o_wdata <= 8'h00;
      o_wdata_vld <= 1'h0;
      o_rd_req <= 1'h0;
      tx_q <= 8'h00;
      tx_en_q <= 1'h0;
    end else begin
      pause_q <= pause_d;
      o_cmd_vld <= 1'h0;
      o_addr_vld <= 1'h0;
      o_wdata_vld <= 1'h0;
      o_rd_req <= 1'h0;
      if (cs_n) begin
        cnt_q <= 4'h0;
        phase_q <= `SSW_PH_CMD;
        abytes_q <= 2'h0;
        tx_en_q <= 1'h0;
      end else if (active & sck_rise) begin
        sh_q <= sh_d;
        cnt_q <= byte_done ? 4'h0 : cnt_d;
        if (byte_done) begin
          case (phase_q)
            `SSW_PH_CMD: begin
              o_cmd <= sh_d;
              o_cmd_vld <= 1'h1;
              phase_q <= `SSW_PH_ADDR;
              width_q <= cmd_width(sh_d, width_q);
            end
            `SSW_PH_ADDR: begin
              o_addr <= {o_addr[7:0], sh_d};
              abytes_q <= abytes_q + 2'h1;
              if (abytes_q + 2'h1 == `SSW_ADDR_BYTES) begin
                o_addr_vld <= 1'h1;
                phase_q <= `SSW_PH_DATA;
                o_rd_req <= i_rd_dir;
              end
            end
            default: begin
              if (!i_rd_dir) begin
                o_wdata <= sh_d;
                o_wdata_vld <= 1'h1;
              end else begin
                o_rd_req <= 1'h1;
              end
            end
          endcase
        end
      end else if (active & sck_fall) begin
        // Output shifter advances after the falling edge
        if (phase_q == `SSW_PH_DATA && i_rd_dir) begin
          if (cnt_q == 4'h0) begin
            tx_q <= i_rdata;
          end else begin
            tx_q <= tx_q << step;
          end
          tx_en_q <= 1'h1;
        end
      end
    end
  end

  // ***********************************************
  // Pin drivers
  // ***********************************************
  // Single and dual float at once on pause
  wire drive_ok = tx_en_q & ~cs_n;
  wire drive_held = drive_ok & ~pause_now;
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      o_line0 <= 1'h0;
      o_line1 <= 1'h0;
      o_line2 <= 1'h0;
      o_line3 <= 1'h0;
      o_line0_oe <= 1'h0;
      o_line1_oe <= 1'h0;
      o_line2_oe <= 1'h0;
      o_line3_oe <= 1'h0;
      o_width <= `SSW_WIDTH_SINGLE;
      o_paused <= 1'h0;
    end else begin
      o_width <= width_q;
      o_paused <= pause_q;
      o_line0 <= 1'h0;
      o_line2 <= 1'h0;
      o_line3 <= 1'h0;
      o_line0_oe <= 1'h0;
      o_line2_oe <= 1'h0;
      o_line3_oe <= 1'h0;
      case (width_q)
        `SSW_WIDTH_DUAL: begin
          o_line1 <= tx_q[7];
          o_line0 <= tx_q[6];
          o_line1_oe <= drive_held;
          o_line0_oe <= drive_held;
        end
        `SSW_WIDTH_QUAD: begin
          o_line3 <= tx_q[7];
          o_line2 <= tx_q[6];
          o_line1 <= tx_q[5];
          o_line0 <= tx_q[4];
          o_line3_oe <= drive_ok;
          o_line2_oe <= drive_ok;
          o_line1_oe <= drive_ok;
          o_line0_oe <= drive_ok;
        end
        default: begin
          o_line1 <= tx_q[7];
          o_line1_oe <= drive_held;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [verilog/ssw_map.vh]
// Constants for the serial SRAM wide-I/O link front end
`ifndef SSW_MAP_VH
`define SSW_MAP_VH
`define SSW_CMD_ENTER_DUAL 8'h3b
`define SSW_CMD_ENTER_QUAD 8'h38
`define SSW_CMD_EXIT_WIDE 8'hff
`define SSW_WIDTH_SINGLE 2'h0
`define SSW_WIDTH_DUAL 2'h1
`define SSW_WIDTH_QUAD 2'h2
`define SSW_PH_CMD 2'h0
`define SSW_PH_ADDR 2'h1
`define SSW_PH_DATA 2'h2
`define SSW_ADDR_BYTES 2'h2
`endif

// [tb/ssw_link_monitor.sv]
// Checker for the serial SRAM link front end
`timescale 1ns/100ps
`default_nettype none
module ssw_link_monitor (
  input wire i_clk, input wire i_rstn, input wire i_line3,
  input wire o_line1_oe, input wire [7:0] o_cmd, input wire o_cmd_vld,
  input wire o_addr_vld, input wire o_wdata_vld, input wire [1:0] o_width,
  input wire o_paused
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_cmd(c);
    o_cmd_vld && o_cmd == c;
  endsequence
  property p_pulse;
    o_cmd_vld |=> !o_cmd_vld;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command pulse too long");
  property p_dual;
    s_cmd(8'h3b) and o_width == 2'h0 |=> o_width == 2'h1;
  endproperty
  a_dual: assert property (p_dual) else $error("dual entry missed");
  property p_quad;
    s_cmd(8'h38) and o_width == 2'h0 |=> o_width == 2'h2;
  endproperty
  a_quad: assert property (p_quad) else $error("quad entry missed");
  property p_exit;
    s_cmd(8'hff) |=> o_width == 2'h0;
  endproperty
  a_exit: assert property (p_exit) else $error("exit missed");
  property p_wchg;
    $changed(o_width) |-> $past(o_cmd_vld);
  endproperty
  a_wchg: assert property (p_wchg) else $error("width changed without command");
  property p_nopause;
    o_width == 2'h2 |-> !o_paused;
  endproperty
  a_nopause: assert property (p_nopause) else $error("pause in quad");
  property p_quiet;
    o_paused |-> !o_cmd_vld && !o_addr_vld && !o_wdata_vld;
  endproperty
  a_quiet: assert property (p_quiet) else $error("byte while paused");
  property p_float;
    !i_line3 && o_width != 2'h2 |-> ##[1:3] !o_line1_oe;
  endproperty
  a_float: assert property (p_float) else $error("output driven in pause");
endmodule
bind ssw_link ssw_link_monitor i_mon(.i_clk(i_clk), .i_rstn(i_rstn), .i_line3(i_line3),
  .o_line1_oe(o_line1_oe), .o_cmd(o_cmd), .o_cmd_vld(o_cmd_vld), .o_addr_vld(o_addr_vld),
  .o_wdata_vld(o_wdata_vld), .o_width(o_width), .o_paused(o_paused));
`default_nettype wire

// [tb/ssw_host.sv]
// Host controller model driving the serial link
`timescale 1ns/100ps
`default_nettype none
module ssw_host (
  input wire logic i_clk,
  input wire logic [3:0] i_d,
  output logic o_cs_n,
  output logic o_sck,
  output logic [3:0] o_d
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_d = 4'hf;
  end
  task wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task sel(input logic on);
    o_cs_n <= !on;
    wt(8);
  endtask
  task send(input logic [7:0] v, input int w);
    logic [7:0] s;
    s = v;
    for (int i = 0; i < 8; i += (1 << w)) begin
      o_d <= w == 2 ? s[7:4] : w == 1 ? {2'b11, s[7:6]} : {3'b111, s[7]};
      s = s << (1 << w);
      wt(4);
      o_sck <= 1'b1;
      wt(4);
      o_sck <= 1'b0;
    end
    wt(4);
  endtask
  task recv(input int w, output logic [7:0] r);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i += (1 << w)) begin
      wt(4);
      o_sck <= 1'b1;
      wt(4);
      s = (s << (1 << w)) | (w == 2 ? i_d : w == 1 ? i_d[1:0] : i_d[1]);
      o_sck <= 1'b0;
    end
    wt(4);
    r = s;
  endtask
  task junk;
    repeat (3) begin
      o_d[0] <= ~o_d[0];
      o_sck <= 1'b1;
      wt(4);
      o_sck <= 1'b0;
      wt(4);
    end
  endtask
  task pause(input logic on);
    o_d[3] <= !on;
    wt(8);
  endtask
endmodule
`default_nettype wire

// [tb/ssw_link_bench.sv]
// Testbench for the serial SRAM link front end
`timescale 1ns/100ps
`default_nettype none
module ssw_link_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic rd_dir = 1'b0;
  wire cs_n, sck, cv, av, wv, pz, rq;
  int n_rq = 0;
  wire [3:0] hd, lo, oe, ln;
  wire [7:0] cmd, wd;
  wire [15:0] adr;
  wire [1:0] wid;
  int n_errors = 0;
  int comparisons = 0;
  assign ln = (oe & lo) | (~oe & hd);
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (rq) n_rq <= n_rq + 1;
  ssw_host i_host(.i_clk(clk), .i_d(ln), .o_cs_n(cs_n), .o_sck(sck), .o_d(hd));
  ssw_link i_dut(.i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sck(sck), .i_line0(ln[0]),
    .i_line1(ln[1]), .i_line2(ln[2]), .i_line3(ln[3]), .o_line0(lo[0]), .o_line0_oe(oe[0]),
    .o_line1(lo[1]), .o_line1_oe(oe[1]), .o_line2(lo[2]), .o_line2_oe(oe[2]), .o_line3(lo[3]),
    .o_line3_oe(oe[3]), .o_cmd(cmd), .o_cmd_vld(cv), .o_addr(adr), .o_addr_vld(av), .o_wdata(wd),
    .o_wdata_vld(wv), .o_rd_req(rq), .i_rdata(rdata), .i_rd_dir(rd_dir), .o_width(wid), .o_paused(pz));
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask
  task complete_run;
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t_dual;
    i_host.sel(1); i_host.send(8'h3b, 0); i_host.sel(0);
    chk("cmd", 16'h3b, cmd);
    chk("width", 16'h1, wid);
    i_host.sel(1); i_host.send(8'h02, 1); i_host.send(8'h12, 1); i_host.send(8'h34, 1);
    chk("addr", 16'h1234, adr);
    i_host.send(8'ha5, 1);
    chk("wdata", 16'ha5, wd);
    i_host.sel(0); i_host.sel(1); i_host.send(8'hff, 1); i_host.sel(0);
    chk("width", 16'h0, wid);
  endtask
  task t_quad;
    i_host.sel(1); i_host.send(8'h38, 0); i_host.sel(0);
    chk("width", 16'h2, wid);
    i_host.sel(1); i_host.send(8'h02, 2); i_host.send(8'hab, 2); i_host.send(8'hcd, 2);
    chk("addr", 16'habcd, adr);
    i_host.sel(0); i_host.sel(1); i_host.send(8'hff, 2); i_host.sel(0);
    chk("width", 16'h0, wid);
  endtask
  task t_pause;
    i_host.sel(1); i_host.send(8'h02, 0); i_host.pause(1);
    chk("paused", 16'h1, pz);
    chk("oe1", 16'h0, oe[1]);
    i_host.junk(); i_host.pause(0);
    chk("paused", 16'h0, pz);
    i_host.send(8'h56, 0); i_host.send(8'h78, 0);
    chk("addr", 16'h5678, adr);
    i_host.sel(0);
  endtask
  task t_read;
    logic [7:0] r;
    int q0;
    q0 = n_rq;
    rd_dir <= 1'b1;
    rdata <= 8'hc6;
    i_host.sel(1);
    i_host.send(8'h03, 0);
    i_host.send(8'h00, 0);
    i_host.send(8'h10, 0);
    i_host.recv(0, r);
    chk("rdata", 16'hc6, r);
    chk("rd_req", 16'h2, n_rq - q0);
    i_host.pause(1);
    chk("oe1", 16'h0, oe[1]);
    i_host.pause(0);
    chk("oe1", 16'h1, oe[1]);
    i_host.sel(0);
    rdata <= 8'h5a;
    i_host.sel(1);
    i_host.send(8'h3b, 0);
    i_host.sel(0);
    i_host.sel(1);
    i_host.send(8'h03, 1);
    i_host.send(8'h00, 1);
    i_host.send(8'h20, 1);
    i_host.recv(1, r);
    chk("rdata", 16'h5a, r);
    i_host.sel(0);
    i_host.sel(1);
    i_host.send(8'hff, 1);
    i_host.sel(0);
    rd_dir <= 1'b0;
    chk("width", 16'h0, wid);
  endtask
  task t_recover;
    i_host.sel(1);
    i_host.send(8'h3b, 0);
    i_host.sel(0);
    i_host.sel(1);
    i_host.send(8'hff, 2);
    i_host.sel(0);
    i_host.sel(1);
    i_host.send(8'hff, 1);
    i_host.sel(0);
    chk("width", 16'h0, wid);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    chk("width", 16'h0, wid);
    t_dual();
    t_quad();
    t_pause();
    t_read();
    t_recover();
    complete_run();
  end
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
